// ==== core/cic_pkg.sv ====
// constants and types shared by the cascadable capture pair
package cic_pkg;
  localparam int CIC_DATA_W = 16;
  localparam int CIC_ADDR_W = 4;
  localparam int CIC_SYNC_W = 5;
  localparam int CIC_MODE_W = 3;
  localparam int CIC_STAT_W = 4;
  // register indices
  localparam logic [3:0] CIC_CTRL1_LOW = 4'h0;
  localparam logic [3:0] CIC_CTRL2_LOW = 4'h1;
  localparam logic [3:0] CIC_CTRL1_HIGH = 4'h2;
  localparam logic [3:0] CIC_CTRL2_HIGH = 4'h3;
  localparam logic [3:0] CIC_BUF_LOW = 4'h4;
  localparam logic [3:0] CIC_BUF_HIGH = 4'h5;
  localparam logic [3:0] CIC_STATUS = 4'h6;
  localparam logic [3:0] CIC_MASK = 4'h7;
  localparam logic [3:0] CIC_COUNT_LOW = 4'h8;
  localparam logic [3:0] CIC_COUNT_HIGH = 4'h9;
  // field positions
  localparam int CIC_CASC_BIT = 8;
  localparam int CIC_RBNE_BIT = 3;
  localparam int CIC_MODE_LSB = 0;
  localparam int CIC_SYNC_LSB = 0;
  // status bits
  localparam int CIC_ST_CAP_LOW = 0;
  localparam int CIC_ST_CAP_HIGH = 1;
  localparam int CIC_ST_OVF_LOW = 2;
  localparam int CIC_ST_OVF_HIGH = 3;
  // reset values and the count wrap point
  localparam logic [15:0] CIC_CNT_RST = 16'h0000;
  localparam logic [15:0] CIC_CNT_MAX = 16'hffff;
  localparam logic [2:0] CIC_MODE_OFF = 3'h0;
  localparam logic [4:0] CIC_SYNC_FREE = 5'h00;
  typedef enum logic [1:0] {
    CIC_HOLD = 2'b01,
    CIC_RUN = 2'b10
  } cic_run_t;
endpackage : cic_pkg

// ==== core/cic_mem.sv ====
// small result memory with registered read data
`timescale 1ns/1ps
module cic_mem #(
  parameter int W = 16,
  parameter int DEPTH = 4,
  parameter int AW = 2
) (
  // clocking
  input wire logic clk,
  input wire logic ce,
  // write side
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // read side
  input wire logic [AW-1:0] rd_addr,
  output logic [W-1:0] rd_data
);
  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk) begin
    if (ce) begin
      if (wr_en) begin
        mem[wr_addr] <= wr_data;
      end
      rd_data <= mem[rd_addr];
    end
  end
endmodule : cic_mem

// ==== core/cic_capture32.sv ====
// two 16-bit input capture channels that can cascade into one 32-bit channel
// Functional notes
// RL1: by default each channel counts alone
// RL2: odd and even channels pair as one
// RL3: low channel gives low word, high upper
// RL4: low wrap increments the high count
// RL5: cascade only when both enable bits set
// RL6: software sets both channels' sources identically
// RL7: cascaded pair held reset until sync enabled
// RL8: software reads both buffers for 32 bits
// RL9: low not-empty flag means capture waiting
// RL10: both halves latched in one cycle
`timescale 1ns/1ps
module cic_capture32 import cic_pkg::*; #(
  parameter int DEPTH = 4,
  parameter int PTR_W = 2
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic ce,
  // register port
  input wire logic [CIC_ADDR_W-1:0] addr,
  input wire logic [CIC_DATA_W-1:0] wdata,
  input wire logic wr_stb,
  input wire logic rd_stb,
  output logic [CIC_DATA_W-1:0] rdata,
  // capture and sync inputs
  input wire logic cap_low_in,
  input wire logic cap_high_in,
  input wire logic [(1<<CIC_SYNC_W)-1:0] sync_src,
  // interrupt
  output logic irq
);
  localparam logic [PTR_W:0] LVL_FULL = (PTR_W+1)'(DEPTH);
  localparam logic [PTR_W:0] LVL_ONE = (PTR_W+1)'(1);

  function automatic logic sync_ok(input logic [CIC_SYNC_W-1:0] sel,
                                   input logic [(1<<CIC_SYNC_W)-1:0] src);
    sync_ok = (sel == CIC_SYNC_FREE) || src[sel];
  endfunction : sync_ok

  function automatic logic wraps(input logic [CIC_DATA_W-1:0] c);
    wraps = (c == CIC_CNT_MAX);
  endfunction : wraps

  // ****************************************
  // configuration registers
  // ****************************************
  logic [CIC_MODE_W-1:0] mode [2], next_mode [2];
  logic [CIC_SYNC_W-1:0] sync_sel [2], next_sync_sel [2];
  logic casc [2], next_casc [2];
  logic [CIC_STAT_W-1:0] mask, next_mask;
  logic casc_act;

  assign casc_act = casc[0] & casc[1]; // RL2 RL5

  always_comb begin
    next_mode = mode;
    next_sync_sel = sync_sel;
    next_casc = casc;
    next_mask = mask;
    if (wr_stb) begin
      case (addr)
        CIC_CTRL1_LOW: next_mode[0] = wdata[CIC_MODE_LSB +: CIC_MODE_W];
        CIC_CTRL1_HIGH: next_mode[1] = wdata[CIC_MODE_LSB +: CIC_MODE_W];
        CIC_CTRL2_LOW: begin
          next_casc[0] = wdata[CIC_CASC_BIT];
          next_sync_sel[0] = wdata[CIC_SYNC_LSB +: CIC_SYNC_W];
        end
        CIC_CTRL2_HIGH: begin
          next_casc[1] = wdata[CIC_CASC_BIT];
          next_sync_sel[1] = wdata[CIC_SYNC_LSB +: CIC_SYNC_W];
        end
        CIC_MASK: next_mask = wdata[CIC_STAT_W-1:0];
        default: next_mask = mask;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      mode <= '{CIC_MODE_OFF, CIC_MODE_OFF};
      sync_sel <= '{CIC_SYNC_FREE, CIC_SYNC_FREE};
      casc <= '{1'b0, 1'b0};
      mask <= '0;
    end else if (ce) begin
      mode <= next_mode;
      sync_sel <= next_sync_sel;
      casc <= next_casc;
      mask <= next_mask;
    end
  end

  // ****************************************
  // time bases and capture edges
  // ****************************************
  cic_run_t run [2], next_run [2];
  logic [CIC_DATA_W-1:0] cnt [2], next_cnt [2];
  logic cap_prev [2], next_cap_prev [2];
  logic go [2];
  logic edge_hit [2];
  logic push_req [2];

  always_comb begin
    // odd channel owns mode and sync for the pair; the even one follows
    go[0] = (mode[0] != CIC_MODE_OFF) && sync_ok(sync_sel[0], sync_src); // RL7
    go[1] = casc_act ? go[0] :
            ((mode[1] != CIC_MODE_OFF) && sync_ok(sync_sel[1], sync_src)); // RL1
    next_cap_prev[0] = cap_low_in;
    next_cap_prev[1] = cap_high_in;
    edge_hit[0] = cap_low_in & ~cap_prev[0];
    edge_hit[1] = cap_high_in & ~cap_prev[1];
    for (int i = 0; i < 2; i++) begin
      next_run[i] = go[i] ? CIC_RUN : CIC_HOLD;
      next_cnt[i] = CIC_CNT_RST;
    end
    push_req[0] = (run[0] == CIC_RUN) && edge_hit[0];
    // one edge on the low pin latches both halves together
    push_req[1] = casc_act ? push_req[0] : ((run[1] == CIC_RUN) && edge_hit[1]); // RL10
    case (run[0])
      CIC_RUN: next_cnt[0] = go[0] ? cnt[0] + 16'h0001 : CIC_CNT_RST;
      CIC_HOLD: next_cnt[0] = CIC_CNT_RST;
      default: next_cnt[0] = CIC_CNT_RST;
    endcase
    case (run[1])
      CIC_RUN: begin
        if (!go[1]) begin
          next_cnt[1] = CIC_CNT_RST;
        end else if (casc_act) begin
          next_cnt[1] = wraps(cnt[0]) ? cnt[1] + 16'h0001 : cnt[1]; // RL4
        end else begin
          next_cnt[1] = cnt[1] + 16'h0001; // RL1
        end
      end
      CIC_HOLD: next_cnt[1] = CIC_CNT_RST;
      default: next_cnt[1] = CIC_CNT_RST;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      run <= '{CIC_HOLD, CIC_HOLD};
      cnt <= '{CIC_CNT_RST, CIC_CNT_RST};
      cap_prev <= '{1'b0, 1'b0};
    end else if (ce) begin
      run <= next_run;
      cnt <= next_cnt;
      cap_prev <= next_cap_prev;
    end
  end

  // ****************************************
  // result buffers and status
  // ****************************************
  logic [PTR_W-1:0] wptr [2], next_wptr [2];
  logic [PTR_W-1:0] rptr [2], next_rptr [2];
  logic [PTR_W:0] level [2], next_level [2];
  logic [CIC_STAT_W-1:0] status, next_status;
  logic push [2];
  logic pop [2];
  logic [CIC_DATA_W-1:0] mem_q [2];

  always_comb begin
    next_wptr = wptr;
    next_rptr = rptr;
    next_level = level;
    next_status = status;
    if (rd_stb && addr == CIC_STATUS) begin
      next_status = '0;
    end
    for (int i = 0; i < 2; i++) begin
      push[i] = push_req[i] && (level[i] != LVL_FULL);
      pop[i] = rd_stb && (addr == (i == 0 ? CIC_BUF_LOW : CIC_BUF_HIGH))
               && (level[i] != '0);
      if (push[i]) begin
        next_wptr[i] = wptr[i] + 1'b1;
      end
      if (pop[i]) begin
        next_rptr[i] = rptr[i] + 1'b1;
      end
      if (push[i] && !pop[i]) begin
        next_level[i] = level[i] + LVL_ONE;
      end else if (pop[i] && !push[i]) begin
        next_level[i] = level[i] - LVL_ONE;
      end
    end
    // sets after the read clear so a same-cycle event survives
    if (push[0]) next_status[CIC_ST_CAP_LOW] = 1'b1;
    if (push[1]) next_status[CIC_ST_CAP_HIGH] = 1'b1;
    if (push_req[0] && !push[0]) next_status[CIC_ST_OVF_LOW] = 1'b1;
    if (push_req[1] && !push[1]) next_status[CIC_ST_OVF_HIGH] = 1'b1;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr <= '{'0, '0};
      rptr <= '{'0, '0};
      level <= '{'0, '0};
      status <= '0;
    end else if (ce) begin
      wptr <= next_wptr;
      rptr <= next_rptr;
      level <= next_level;
      status <= next_status;
    end
  end

  assign irq = |(status & mask);

  for (genvar g = 0; g < 2; g++) begin : g_buf
    // low memory holds the low word, high memory the upper word
    cic_mem #(.W(CIC_DATA_W), .DEPTH(DEPTH), .AW(PTR_W)) u_mem (
      .clk(clk),
      .ce(ce),
      .wr_en(push[g]),
      .wr_addr(wptr[g]),
      .wr_data(cnt[g]), // RL3
      .rd_addr(rptr[g]),
      .rd_data(mem_q[g])
    );
  end

  // ****************************************
  // read path
  // ****************************************
  logic [CIC_DATA_W-1:0] rd_reg, next_rd_reg;
  logic [1:0] rd_sel, next_rd_sel;

  always_comb begin
    next_rd_reg = '0;
    next_rd_sel = 2'h0;
    if (rd_stb) begin
      next_rd_sel = 2'h1;
      case (addr)
        CIC_CTRL1_LOW: begin
          next_rd_reg[CIC_MODE_LSB +: CIC_MODE_W] = mode[0];
          next_rd_reg[CIC_RBNE_BIT] = (level[0] != '0); // RL9
        end
        CIC_CTRL1_HIGH: begin
          next_rd_reg[CIC_MODE_LSB +: CIC_MODE_W] = mode[1];
          next_rd_reg[CIC_RBNE_BIT] = (level[1] != '0);
        end
        CIC_CTRL2_LOW: begin
          next_rd_reg[CIC_CASC_BIT] = casc[0];
          next_rd_reg[CIC_SYNC_LSB +: CIC_SYNC_W] = sync_sel[0];
        end
        CIC_CTRL2_HIGH: begin
          next_rd_reg[CIC_CASC_BIT] = casc[1];
          next_rd_reg[CIC_SYNC_LSB +: CIC_SYNC_W] = sync_sel[1];
        end
        CIC_BUF_LOW: next_rd_sel = (level[0] != '0) ? 2'h2 : 2'h1;
        CIC_BUF_HIGH: next_rd_sel = (level[1] != '0) ? 2'h3 : 2'h1;
        CIC_STATUS: next_rd_reg[CIC_STAT_W-1:0] = status;
        CIC_MASK: next_rd_reg[CIC_STAT_W-1:0] = mask;
        CIC_COUNT_LOW: next_rd_reg = cnt[0];
        CIC_COUNT_HIGH: next_rd_reg = cnt[1];
        default: next_rd_reg = '0;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rd_reg <= '0;
      rd_sel <= 2'h0;
    end else if (ce) begin
      rd_reg <= next_rd_reg;
      rd_sel <= next_rd_sel;
    end
  end

  // empty buffer reads as zero; answer stands only the cycle after the strobe
  assign rdata = (rd_sel == 2'h2) ? mem_q[0] : (rd_sel == 2'h3) ? mem_q[1] :
                 (rd_sel == 2'h1) ? rd_reg : '0;

  // ****************************************
  // checks
  // ****************************************
  sequence low_wrap_s;
    ce && casc_act && run[0] == CIC_RUN && go[0] && wraps(cnt[0]);
  endsequence

  indep_count_a: assert property (@(posedge clk) disable iff (sys_rst) // RL1
    ce && !casc_act && run[1] == CIC_RUN && go[1] |=> cnt[1] == $past(cnt[1]) + 16'h0001)
    else $error("independent high count did not step");
  pair_push_a: assert property (@(posedge clk) disable iff (sys_rst) // RL2
    ce && casc_act && run[0] == CIC_RUN && cap_low_in && !cap_prev[0] |-> push_req[1])
    else $error("cascaded pair did not capture together");
  word_order_a: assert property (@(posedge clk) disable iff (sys_rst) // RL3
    ce && casc_act && push[0] && push[1] |=> g_buf[0].u_mem.mem[$past(wptr[0])] == $past(cnt[0])
      && g_buf[1].u_mem.mem[$past(wptr[1])] == $past(cnt[1]))
    else $error("halves stored in wrong buffers");
  wrap_carry_a: assert property (@(posedge clk) disable iff (sys_rst) // RL4
    low_wrap_s |=> cnt[1] == $past(cnt[1]) + 16'h0001 && cnt[0] == CIC_CNT_RST)
    else $error("low wrap did not carry");
  no_carry_a: assert property (@(posedge clk) disable iff (sys_rst) // RL5
    ce && !casc_act && run[1] == CIC_RUN && !go[1] |=> cnt[1] == CIC_CNT_RST)
    else $error("high count ran without its own enable");
  sync_hold_a: assert property (@(posedge clk) disable iff (sys_rst) // RL7
    ce && casc_act && !sync_ok(sync_sel[0], sync_src) |=> cnt[0] == CIC_CNT_RST
      && cnt[1] == CIC_CNT_RST ##0 run[1] == CIC_HOLD)
    else $error("cascaded pair left reset before sync");
  not_empty_a: assert property (@(posedge clk) disable iff (sys_rst) // RL9
    ce && rd_stb && addr == CIC_CTRL1_LOW |=> rdata[CIC_RBNE_BIT] == ($past(level[0]) != '0))
    else $error("not-empty flag wrong");
  same_cycle_a: assert property (@(posedge clk) disable iff (sys_rst) // RL10
    ce && casc_act && push[0] && level[1] != LVL_FULL |-> push[1])
    else $error("halves latched in different cycles");
endmodule : cic_capture32

// ==== dv/cic_pin_model.sv ====
// far-side model: the two external capture pins
`timescale 1ns/1ps
module cic_pin_model (
  // clock
  input wire logic clk,
  // commands from the bench
  input wire logic fire_low,
  input wire logic fire_high,
  // capture pins
  output logic cap_low_in,
  output logic cap_high_in
);
  initial begin
    cap_low_in = 1'b0;
    cap_high_in = 1'b0;
  end
  // pins change only after an edge, so the design never samples a moving level
  always @(posedge clk) begin
    cap_low_in <= fire_low;
    cap_high_in <= fire_high;
  end
endmodule : cic_pin_model

// ==== dv/test_input_capture_cascade_32bit.sv ====
// self-checking bench for the cascadable capture pair
`timescale 1ns/1ps
module test_input_capture_cascade_32bit;
  import cic_pkg::*;
  logic clk = 1'b0;
  logic sys_rst = 1'b1;
  logic wr_stb = 1'b0;
  logic rd_stb = 1'b0;
  logic fire_low = 1'b0;
  logic fire_high = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000;
  logic [31:0] sync_src = 32'h00000000;
  logic [15:0] rdata;
  logic irq;
  logic cap_low_in;
  logic cap_high_in;
  logic [15:0] d;
  int n_mismatch = 0;
  int n_checks = 0;

  always #12.5 clk = ~clk;

  cic_capture32 #(.DEPTH(4), .PTR_W(2)) u_dut (.clk(clk), .sys_rst(sys_rst), .ce(1'b1),
    .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata),
    .cap_low_in(cap_low_in), .cap_high_in(cap_high_in), .sync_src(sync_src), .irq(irq));

  cic_pin_model u_pins (.clk(clk), .fire_low(fire_low), .fire_high(fire_high),
    .cap_low_in(cap_low_in), .cap_high_in(cap_high_in));

  // ***************
  // shared tasks
  // ***************
  task check(input string what, input logic [15:0] exp, input logic [15:0] got);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  task wr(input logic [3:0] a, input logic [15:0] v);
    @(posedge clk);
    addr <= a;
    wdata <= v;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask : wr

  // data stand only in the cycle after the strobe edge
  task rd(input logic [3:0] a, output logic [15:0] v);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1 v = rdata;
  endtask : rd

  task pulse(input logic hi);
    @(posedge clk);
    if (hi) fire_high <= 1'b1;
    else fire_low <= 1'b1;
    repeat (3) @(posedge clk);
    fire_high <= 1'b0;
    fire_low <= 1'b0;
    repeat (4) @(posedge clk);
  endtask : pulse

  task final_report;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  // ***************
  // scenarios
  // ***************
  task t_reset_and_unmapped;
    rd(CIC_STATUS, d);
    check("status_after_reset", 16'h0000, d);
    wr(4'hf, 16'hffff);
    rd(4'hf, d);
    check("unmapped_read", 16'h0000, d);
  endtask : t_reset_and_unmapped

  task t_independent;
    wr(CIC_CTRL1_LOW, 16'h0001);
    repeat (20) @(posedge clk);
    rd(CIC_COUNT_LOW, d);
    check("low_count_runs", 16'h0014, d);
    rd(CIC_COUNT_HIGH, d);
    check("high_count_alone", 16'h0000, d);
    wr(CIC_CTRL1_LOW, 16'h0000);
  endtask : t_independent

  task t_alone_and_overflow;
    // one cascade bit alone must leave both channels independent
    wr(CIC_CTRL2_LOW, 16'h0100);
    wr(CIC_CTRL1_HIGH, 16'h0001);
    wr(CIC_CTRL1_LOW, 16'h0001);
    repeat (5) pulse(1'b0);
    pulse(1'b1);
    rd(CIC_CTRL2_LOW, d);
    check("ctrl2_readback", 16'h0100, d);
    rd(CIC_COUNT_HIGH, d);
    check("high_counts_alone", 16'h0001, {15'h0000, d > 16'h0010});
    // four low captures fill the buffer, the fifth overflows
    rd(CIC_STATUS, d);
    check("status_caps_overflow", 16'h0007, d);
    rd(CIC_CTRL1_HIGH, d);
    check("high_not_empty", 16'h0009, d);
    // mid-run reset drains the buffers before the cascade test
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    rd(CIC_CTRL1_LOW, d);
    check("reset_clears_ctrl1", 16'h0000, d);
    rd(CIC_COUNT_HIGH, d);
    check("reset_clears_count", 16'h0000, d);
    rd(CIC_CTRL2_LOW, d);
    check("reset_clears_ctrl2", 16'h0000, d);
  endtask : t_alone_and_overflow

  task t_cascade;
    logic [15:0] lo;
    // even module first, identical sync selection on both
    wr(CIC_CTRL2_HIGH, 16'h0103);
    wr(CIC_CTRL2_LOW, 16'h0103);
    wr(CIC_MASK, 16'h0001);
    wr(CIC_CTRL1_LOW, 16'h0001);
    repeat (10) @(posedge clk);
    rd(CIC_COUNT_LOW, d);
    check("held_until_sync", 16'h0000, d);
    @(posedge clk);
    sync_src[3] <= 1'b1;
    repeat (65550) @(posedge clk);
    rd(CIC_COUNT_HIGH, d);
    check("carry_into_high", 16'h0001, d);
    pulse(1'b1);
    rd(CIC_STATUS, d);
    check("high_pin_ignored", 16'h0000, {15'h0000, d[CIC_ST_CAP_HIGH]});
    pulse(1'b0);
    rd(CIC_CTRL1_LOW, d);
    check("not_empty_set", 16'h0001, {15'h0000, d[CIC_RBNE_BIT]});
    check("irq_raised", 16'h0001, {15'h0000, irq});
    rd(CIC_STATUS, d);
    check("status_low_cap", 16'h0001, {15'h0000, d[CIC_ST_CAP_LOW]});
    @(posedge clk);
    check("irq_cleared", 16'h0000, {15'h0000, irq});
    rd(CIC_BUF_LOW, lo);
    check("low_word_recent", 16'h0001, {15'h0000, lo < 16'd200});
    rd(CIC_BUF_HIGH, d);
    check("high_word", 16'h0001, d);
    rd(CIC_CTRL1_LOW, d);
    check("not_empty_clear", 16'h0000, {15'h0000, d[CIC_RBNE_BIT]});
    wr(CIC_MASK, 16'h0000);
    pulse(1'b0);
    check("irq_masked", 16'h0000, {15'h0000, irq});
  endtask : t_cascade

  // ***************
  // main sequence
  // ***************
  initial begin
    repeat (4) @(posedge clk);
    sys_rst <= 1'b0;
    t_reset_and_unmapped();
    t_independent();
    t_alone_and_overflow();
    t_cascade();
    final_report();
  end

  // the long carry wait dominates the run; allow some margin above it
  initial begin
    #(70000 * 25);
    n_mismatch++;
    final_report();
  end
endmodule : test_input_capture_cascade_32bit
